// ---- vdc_consts.vh ----
`ifndef VDC_CONSTS_VH
`define VDC_CONSTS_VH
// register indices (printed offsets are not multiples of four: byte address = 4 * index)
`define VDC_IDX_LINK_CFG      8'h28
`define VDC_IDX_DITHER_CFG    8'h29
`define VDC_IDX_COLOR_CTL     8'h2a
`define VDC_IDX_RX_MODE       8'h34
// reset values
`define VDC_RST_LINK_CFG      8'h20
`define VDC_RST_DITHER_CFG    8'h00
`define VDC_RST_COLOR_CTL     8'h00
`define VDC_RST_RX_MODE       2'h0
// writable masks
`define VDC_MASK_LINK_CFG     8'hbf
`define VDC_MASK_COLOR_CTL    8'hf0
// link_datapath_config fields
`define VDC_B_REMOTE_BLOCK    7
`define VDC_B_VIDEO_OFF       5
`define VDC_B_TWO_LANE        4
`define VDC_B_ALT_AUDIO       3
`define VDC_B_AUDIO_OFF       2
`define VDC_B_SYNC_VIDEO      1
`define VDC_B_SURROUND        0
// dither_sync_config fields
`define VDC_B_TIMING_SYNC     7
`define VDC_B_HS_LEVEL        6
`define VDC_B_VS_LEVEL        5
`define VDC_B_DE_LEVEL        4
`define VDC_B_DITH_B_ON       3
`define VDC_B_DITH_A_ON       2
`define VDC_B_DITH_B_HI_OFF   1
`define VDC_B_DITH_A_HI_OFF   0
// color_correction_control fields
`define VDC_B_PAGE_HI         7
`define VDC_B_PAGE_LO         6
`define VDC_B_WB_ON           5
`define VDC_B_TABLE_REFRESH   4
// receive input mode codes
`define VDC_RX_AUTO           2'h0
`define VDC_RX_FORCE_TWO      2'h1
`define VDC_RX_FORCE_ONE_PRI  2'h2
`define VDC_RX_FORCE_ONE_SEC  2'h3
// answers
`define VDC_RESP_OKAY         2'h0
`define VDC_RESP_SLVERR       2'h2
`endif

// ---- vdc_regs.v ----
`timescale 1ns/1ns
`include "vdc_consts.vh"

// Contract
// - remote_load_block set blocks forward-channel writes of link config; clear allows them.
// - forward-video-off resets to one, flags no active video; control stays operational.
// - two-lane bit gives serializer lane count; used for recovery in auto-detect.
// - alternate audio bit routes word clock to aux pin one, data to zero.
// - bit 2 disables audio output; bit 0 enables surround audio.
// - sync-carrying video bit selects 28-bit video with embedded syncs.
// - timing select: 0 data-enable only, 1 sync timing.
// - three polarity bits: 0 active high, 1 active low, independent.
// - dither stage enables: bit 3 stage b, bit 2 stage a.
// - high-mode bits inverted: 0 enables high mode; bit 1 b, bit 0 a.
// - page field selects config, red, green or blue table.
// - white balance enable applies correction lookup, else bypass.
// - table refresh bit permits lookup table reloads.
// - receive input mode 01 forces two-lane, overriding the two-lane bit.
module vdc_regs (
	// clock and reset
	input  wire        clk,
	input  wire        reset_n,
	// axi4-lite write address
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// forward-channel load of link config (same clock)
	input  wire [7:0]  fwd_cfg_data,
	input  wire        fwd_cfg_load,
	// forward-channel video status (same clock)
	input  wire        fwd_video_active,
	// datapath controls
	output reg         two_lane_recover,
	output reg         aux_audio_route,
	output reg         audio_out_off,
	output reg         surround_on,
	output reg         sync_video_28,
	output reg         video_off,
	output reg         timing_sync_mode,
	output reg         hsync_level_sel,
	output reg         vsync_level_sel,
	output reg         data_enable_level_sel,
	output reg         dither_stage_a_on,
	output reg         dither_stage_b_on,
	output reg         dither_stage_a_high_on,
	output reg         dither_stage_b_high_on,
	output reg  [1:0]  table_page,
	output reg         white_balance_on,
	output reg         table_refresh_on
);

	////////////////////////////////////////////////////////////////////////
	// address decode, shared by read and write
	localparam [1:0] SEL_LINK   = 2'h0;
	localparam [1:0] SEL_DITHER = 2'h1;
	localparam [1:0] SEL_COLOR  = 2'h2;
	localparam [1:0] SEL_NONE   = 2'h3;

	function [1:0] vdc_decode;
		input [31:0] addr;
		begin
			if (addr[1:0] != 2'h0 || addr[31:10] != 22'h0)
				vdc_decode = SEL_NONE;
			else if (addr[9:2] == `VDC_IDX_LINK_CFG)
				vdc_decode = SEL_LINK;
			else if (addr[9:2] == `VDC_IDX_DITHER_CFG)
				vdc_decode = SEL_DITHER;
			else if (addr[9:2] == `VDC_IDX_COLOR_CTL)
				vdc_decode = SEL_COLOR;
			else
				vdc_decode = SEL_NONE;
		end
	endfunction

	// receive mode sits outside the three-way select
	function vdc_is_rx;
		input [31:0] addr;
		begin
			vdc_is_rx = (addr[31:10] == 22'h0) && (addr[1:0] == 2'h0) && (addr[9:2] == `VDC_IDX_RX_MODE);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// storage
	reg  [7:0] link_cfg;
	reg  [7:0] dither_cfg;
	reg  [7:0] color_ctl;
	// receive input mode, bits 4:3 of its own word
	reg  [1:0] rx_mode;

	// write channel: both address and data captured, either order
	reg        aw_held;
	reg        w_held;
	reg [31:0] aw_addr;
	reg [31:0] w_data;
	reg        w_lane0;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	wire        aw_now  = aw_held || (s_axi_awvalid && s_axi_awready);
	wire        w_now   = w_held || (s_axi_wvalid && s_axi_wready);
	wire [31:0] wa      = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wd      = w_held ? w_data : s_axi_wdata;
	wire        wl0     = w_held ? w_lane0 : s_axi_wstrb[0];
	wire        do_wr   = aw_now && w_now && !s_axi_bvalid;
	wire        wr_rx   = vdc_is_rx(wa);
	wire [1:0]  wr_sel  = vdc_decode(wa);
	wire        wr_hit  = wr_rx || (wr_sel != SEL_NONE);
	wire        sw_en   = do_wr && wr_hit && wl0;

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (!reset_n) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 32'h0;
			w_data       <= 32'h0;
			w_lane0      <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `VDC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready && !do_wr) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready && !do_wr) begin
				w_held  <= 1'b1;
				w_data  <= s_axi_wdata;
				w_lane0 <= s_axi_wstrb[0];
			end
			// answer once both halves are in; bvalid then blocks both readies
			if (do_wr) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `VDC_RESP_OKAY : `VDC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per-register write strobes
	wire        wr_link   = sw_en && !wr_rx && wr_sel == SEL_LINK;
	wire        wr_dither = sw_en && !wr_rx && wr_sel == SEL_DITHER;
	wire        wr_color  = sw_en && !wr_rx && wr_sel == SEL_COLOR;
	wire        wr_mode   = sw_en && wr_rx;

	// software write wins over a same-cycle forward load, so a local fix is never lost
	always @(posedge clk) begin
		if (!reset_n)
			link_cfg <= `VDC_RST_LINK_CFG;
		else if (wr_link)
			link_cfg <= wd[7:0] & `VDC_MASK_LINK_CFG;
		else if (fwd_cfg_load && !link_cfg[`VDC_B_REMOTE_BLOCK])
			link_cfg <= {1'b0, 1'b0, fwd_cfg_data[5:0]};
	end

	// every dither bit is writable, so no mask
	always @(posedge clk) begin
		if (!reset_n)
			dither_cfg <= `VDC_RST_DITHER_CFG;
		else if (wr_dither)
			dither_cfg <= wd[7:0];
	end

	// reserved low nibble never reaches storage, so reads of it stay zero
	always @(posedge clk) begin
		if (!reset_n)
			color_ctl <= `VDC_RST_COLOR_CTL;
		else if (wr_color)
			color_ctl <= wd[7:0] & `VDC_MASK_COLOR_CTL;
	end

	// only bits 4:3 of the mode word are kept
	always @(posedge clk) begin
		if (!reset_n)
			rx_mode <= `VDC_RST_RX_MODE;
		else if (wr_mode)
			rx_mode <= wd[4:3];
	end

	////////////////////////////////////////////////////////////////////////
	// read channel, one cycle after the address is taken
	// data is registered so it stands until rready; unmapped words answer zero with an error
	wire        rd_rx  = vdc_is_rx(s_axi_araddr);
	wire [1:0]  rd_sel = vdc_decode(s_axi_araddr);
	reg  [31:0] rd_word;

	always @* begin
		rd_word = 32'h0;
		if (rd_rx)
			rd_word = {27'h0, rx_mode, 3'h0};
		else case (rd_sel)
			SEL_LINK:   rd_word = {24'h0, link_cfg};
			SEL_DITHER: rd_word = {24'h0, dither_cfg};
			SEL_COLOR:  rd_word = {24'h0, color_ctl};
			default: rd_word = 32'h0;
		endcase
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `VDC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= (rd_rx || rd_sel != SEL_NONE) ? `VDC_RESP_OKAY : `VDC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link-derived controls, one cycle behind the register
	always @(posedge clk) begin
		if (!reset_n) begin
			two_lane_recover <= 1'b0;
			aux_audio_route  <= 1'b0;
			audio_out_off    <= 1'b0;
			surround_on      <= 1'b0;
			sync_video_28    <= 1'b0;
			video_off        <= 1'b1;
		end else begin
			// forced two-lane overrides, forced one-lane clears, auto uses the bit
			case (rx_mode)
				`VDC_RX_AUTO:      two_lane_recover <= link_cfg[`VDC_B_TWO_LANE];
				`VDC_RX_FORCE_TWO: two_lane_recover <= 1'b1;
				default:           two_lane_recover <= 1'b0;
			endcase
			aux_audio_route  <= link_cfg[`VDC_B_ALT_AUDIO];
			audio_out_off    <= link_cfg[`VDC_B_AUDIO_OFF];
			surround_on      <= link_cfg[`VDC_B_SURROUND];
			sync_video_28    <= link_cfg[`VDC_B_SYNC_VIDEO];
			video_off        <= link_cfg[`VDC_B_VIDEO_OFF];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timing and dither controls; high-mode bits stored as written, inverted here
	always @(posedge clk) begin
		if (!reset_n) begin
			timing_sync_mode       <= 1'b0;
			hsync_level_sel        <= 1'b0;
			vsync_level_sel        <= 1'b0;
			data_enable_level_sel  <= 1'b0;
			dither_stage_a_on      <= 1'b0;
			dither_stage_b_on      <= 1'b0;
			dither_stage_a_high_on <= 1'b1;
			dither_stage_b_high_on <= 1'b1;
		end else begin
			timing_sync_mode       <= dither_cfg[`VDC_B_TIMING_SYNC];
			hsync_level_sel        <= dither_cfg[`VDC_B_HS_LEVEL];
			vsync_level_sel        <= dither_cfg[`VDC_B_VS_LEVEL];
			data_enable_level_sel  <= dither_cfg[`VDC_B_DE_LEVEL];
			dither_stage_b_on      <= dither_cfg[`VDC_B_DITH_B_ON];
			dither_stage_a_on      <= dither_cfg[`VDC_B_DITH_A_ON];
			dither_stage_b_high_on <= !dither_cfg[`VDC_B_DITH_B_HI_OFF];
			dither_stage_a_high_on <= !dither_cfg[`VDC_B_DITH_A_HI_OFF];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// lookup page and balance controls
	always @(posedge clk) begin
		if (!reset_n) begin
			table_page       <= 2'h0;
			white_balance_on <= 1'b0;
			table_refresh_on <= 1'b0;
		end else begin
			table_page       <= color_ctl[`VDC_B_PAGE_HI:`VDC_B_PAGE_LO];
			white_balance_on <= color_ctl[`VDC_B_WB_ON];
			table_refresh_on <= color_ctl[`VDC_B_TABLE_REFRESH];
		end
	end

	// fwd_video_active is accepted for future status use; video-off follows the bit
	wire unused_ok = fwd_video_active;

endmodule // vdc_regs

// ---- vdc_regs_monitor.sv ----
`timescale 1ns/1ns
module vdc_monitor (
	// clock and reset
	input wire        clk,
	input wire        reset_n,
	// bus handshakes and read data
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// forward channel
	input wire        fwd_cfg_load,
	// controls
	input wire        two_lane_recover,
	input wire        video_off,
	input wire        hsync_level_sel,
	input wire        white_balance_on
);
	// outputs trail a register change by one edge, so only judge after three quiet ones
	reg	[1:0]	quiet;
	always @(posedge clk) begin
		if (!reset_n || (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready) || fwd_cfg_load)
			quiet <= 2'h0;
		else if (quiet != 2'h3)
			quiet <= quiet + 2'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	reset_vals_a: assert property ($rose(reset_n) |-> video_off && !hsync_level_sel)
		else $error("reset values wrong");
	video_hold_a: assert property (quiet == 2'h3 |-> $stable(video_off))
		else $error("video off moved unprompted");
	lane_hold_a: assert property (quiet == 2'h3 |-> $stable(two_lane_recover))
		else $error("lane select moved unprompted");
	dither_hold_a: assert property (quiet == 2'h3 |-> $stable(hsync_level_sel))
		else $error("sync level moved unprompted");
	color_hold_a: assert property (quiet == 2'h3 |-> $stable(white_balance_on))
		else $error("balance enable moved unprompted");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_rready |=> s_axi_rvalid ##1 !s_axi_rvalid)
		else $error("read answer late");
	upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write answer late");
endmodule // vdc_monitor
bind vdc_regs vdc_monitor vdc_monitor_i (.*);

// ---- vdc_fwd_model.sv ----
`timescale 1ns/1ns
module vdc_fwd_model (
	// clock
	input wire		clk,
	// forward channel
	output logic	[7:0]	fwd_cfg_data = 8'h00,
	output logic		fwd_cfg_load = 1'b0,
	output logic		fwd_video_active = 1'b0
);
	// one-cycle load; data flips afterwards so a stale value never looks valid
	task send(input [7:0] v);
		@(posedge clk);
		fwd_cfg_data <= v;
		fwd_cfg_load <= 1'b1;
		fwd_video_active <= 1'b1;
		@(posedge clk);
		fwd_cfg_load <= 1'b0;
		fwd_cfg_data <= ~v;
	endtask
endmodule // vdc_fwd_model

// ---- video_datapath_config_regs_tb.sv ----
`timescale 1ns/1ns
`include "vdc_consts.vh"
module video_datapath_config_regs_tb;
	localparam [31:0] LA = `VDC_IDX_LINK_CFG * 4;
	localparam [31:0] DA = `VDC_IDX_DITHER_CFG * 4;
	localparam [31:0] CA = `VDC_IDX_COLOR_CTL * 4;
	localparam [31:0] MA = `VDC_IDX_RX_MODE * 4;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, table_page;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fwd_cfg_load, fwd_video_active;
	logic [7:0] fwd_cfg_data, d;
	logic two_lane_recover, aux_audio_route, audio_out_off, surround_on, sync_video_28, video_off, timing_sync_mode;
	logic hsync_level_sel, vsync_level_sel, data_enable_level_sel, dither_stage_a_on, dither_stage_b_on;
	logic dither_stage_a_high_on, dither_stage_b_high_on, white_balance_on, table_refresh_on;
	logic [33:0] exq[$];
	int error_cnt = 0;
	int cmp_count = 0;
	int m;
	vdc_regs vdc_regs_i (.*);
	vdc_fwd_model vdc_fwd_model_i (.*);
	always #50 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task automatic chk(input [33:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task final_report;
		if (error_cnt == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ready sampled mid-cycle equals what the next rising edge sees
	task bus(input rd, input [31:0] a, input [7:0] v, input [3:0] s, input [33:0] e);
		int n;
		logic [4:0] f;
		exq.push_back(e);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_wstrb <= s;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} <= {!rd, !rd, rd, !rd, rd};
		for (n = 0; n < 40; n++) begin
			@(negedge clk);
			f = {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid}
				& {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready};
			@(posedge clk);
			{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} <=
				{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} & ~f;
			if (|f[1:0])
				break;
		end
		if (n == 40) begin
			error_cnt++;
			final_report();
		end
	endtask
	task wr(input [31:0] a, input [7:0] v, input [3:0] s, input [1:0] r);
		bus(1'b0, a, v, s, {r, 32'h0});
		repeat (2) @(negedge clk);
	endtask
	task rd(input [31:0] a, input [7:0] v, input [1:0] r);
		bus(1'b1, a, 8'h0, 4'h0, {r, 24'h0, v});
		@(negedge clk);
	endtask
	always @(negedge clk) begin
		if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
			chk(s_axi_bready ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}, exq.pop_front());
	end
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h3aa2013d));
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		chk({video_off, dither_stage_b_high_on, dither_stage_a_high_on, two_lane_recover}, 4'he);
		rd(LA, `VDC_RST_LINK_CFG, `VDC_RESP_OKAY);
		rd(DA, `VDC_RST_DITHER_CFG, `VDC_RESP_OKAY);
		rd(CA, `VDC_RST_COLOR_CTL, `VDC_RESP_OKAY);
		rd(32'h4, 8'h00, `VDC_RESP_SLVERR);
		wr(32'h4, 8'hff, 4'h1, `VDC_RESP_SLVERR);
		for (m = 0; m < 8; m++) begin
			d = 8'($urandom);
			wr(DA, d, 4'h1, `VDC_RESP_OKAY);
			chk({timing_sync_mode, hsync_level_sel, vsync_level_sel, data_enable_level_sel, dither_stage_b_on,
				dither_stage_a_on, dither_stage_b_high_on, dither_stage_a_high_on}, {d[7:2], ~d[1:0]});
			d = 8'($urandom);
			wr(CA, {m[1:0], d[5:0]}, 4'h1, `VDC_RESP_OKAY);
			rd(CA, {m[1:0], d[5:4], 4'h0}, `VDC_RESP_OKAY);
			chk({table_page, white_balance_on, table_refresh_on}, {m[1:0], d[5:4]});
			d = 8'($urandom);
			wr(LA, d, 4'h1, `VDC_RESP_OKAY);
			wr(LA, ~d, 4'he, `VDC_RESP_OKAY);
			rd(LA, d & 8'hbf, `VDC_RESP_OKAY);
			chk({video_off, aux_audio_route, audio_out_off, sync_video_28, surround_on}, {d[5], d[3:0]});
			wr(MA, {3'h0, m[1:0], 3'h0}, 4'h1, `VDC_RESP_OKAY);
			chk(two_lane_recover, m[1:0] == 2'h0 ? d[4] : m[1:0] == 2'h1);
		end
		wr(LA, 8'h00, 4'h1, `VDC_RESP_OKAY);
		vdc_fwd_model_i.send(8'h7f);
		rd(LA, 8'h3f, `VDC_RESP_OKAY);
		wr(LA, 8'h80, 4'h1, `VDC_RESP_OKAY);
		vdc_fwd_model_i.send(8'h3f);
		rd(LA, 8'h80, `VDC_RESP_OKAY);
		final_report();
	end
endmodule // video_datapath_config_regs_tb
